// file: core/ssd_datapath.v
// Shift and nibble-swap datapath with per-instruction state timing.
// Assumes the core decode issues one op at a time, only while ready is high.
`timescale 1ns/1ns
`include "ssd_map.vh"

// What this block does
// RQ1: A byte left shift moves bits up one place and sends the top bit to carry, 3 bytes and 2 states binary, 2 bytes and 1 state source.
// RQ2: A word left shift does the same over sixteen bits with the same sizes and states.
// RQ3: An arithmetic right shift keeps the top bit, moves the rest down and sends bit zero to carry, 2 states binary, 1 state source.
// RQ4: A logical right shift loads zero on top, moves the rest down and sends bit zero to carry, 3/2 bytes and 2/1 states.
// RQ5: The nibble swap exchanges the accumulator halves in 1 byte and 2 states in both modes.
// RQ6: Single-penalty instructions add 1 state for an I/O port and 2 for a peripheral register.
// RQ7: Double-penalty instructions add 2 states for an I/O port and 3 for a peripheral register.
// RQ8: A single external access adds N+2 states, N being the wait-state count.
// RQ9: A double external access adds 2(N+2) states.
// RQ10: The extra binary-mode byte is an escape prefix that selects the extended map and costs one state.
// RQ11: Shifts change only carry and the nibble swap changes no flag.
module ssd_datapath #(
  parameter WW = 4 // Wait-state count width
) (
  input  wire          mclk,         // Core clock
  input  wire          nrst,         // Async reset, low
  input  wire          op_valid,     // Issue pulse from decode
  input  wire [2:0]    op_sel,       // Operation select
  input  wire          op_word,      // Word operand
  input  wire          binary_mode,  // Binary opcode mode
  input  wire          esc_prefix,   // Escape prefix seen
  input  wire [1:0]    operand_loc,  // Operand location
  input  wire          pen_double,   // Double-penalty class
  input  wire          ext_double,   // Two external accesses
  input  wire [WW-1:0] wait_states,  // Programmed wait states N
  input  wire [15:0]   operand_in,   // Register or accumulator value
  input  wire          carry_in,     // Current carry flag
  output wire          ready,        // Can take an op
  output reg  [15:0]   result_q,     // Result value
  output reg           carry_flag_q, // Carry out
  output reg           carry_we_q,   // Carry write enable
  output reg           result_we_q,  // Result write, cycle after final state
  output reg  [2:0]    op_bytes_q,   // Instruction length
  output reg  [7:0]    op_states_q,  // Total states
  output reg           illegal_q     // Shift without escape in binary mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Shift unit

  // Byte shifts on the low byte
  function [8:0] ssd_shift_byte; // {carry, value}
    input [2:0] sel;
    input [7:0] v;
    begin
      case (sel)
        `SSD_OP_SHL: ssd_shift_byte = {v[7], v[6:0], 1'b0};                     // RQ1
        `SSD_OP_SRA: ssd_shift_byte = {v[0], v[7], v[7:1]};                     // RQ3
        `SSD_OP_SRZ: ssd_shift_byte = {v[0], 1'b0, v[7:1]};                     // RQ4
        default:     ssd_shift_byte = {1'b0, v};
      endcase
    end
  endfunction

  // Word shifts across all sixteen bits
  function [16:0] ssd_shift_word; // {carry, value}
    input [2:0]  sel;
    input [15:0] v;
    begin
      case (sel)
        `SSD_OP_SHL: ssd_shift_word = {v[15], v[14:0], 1'b0};                   // RQ2
        `SSD_OP_SRA: ssd_shift_word = {v[0], v[15], v[15:1]};                   // RQ3
        `SSD_OP_SRZ: ssd_shift_word = {v[0], 1'b0, v[15:1]};                    // RQ4
        default:     ssd_shift_word = {1'b0, v};
      endcase
    end
  endfunction

  function [16:0] ssd_shift; // {carry, value}
    input [2:0]  sel;
    input        word;
    input [15:0] v;
    input        c;
    reg   [8:0]  b;
    begin
      b = ssd_shift_byte(sel, v[7:0]);
      if (sel == `SSD_OP_SWAP) begin
        ssd_shift = {c, 8'h00, v[3:0], v[7:4]};                                 // RQ5 RQ11
      end else if (!ssd_is_shift(sel)) begin
        ssd_shift = {c, v};
      end else if (word) begin
        ssd_shift = ssd_shift_word(sel, v);                                     // RQ2
      end else begin
        ssd_shift = {b[8], 8'h00, b[7:0]};                                      // RQ1 RQ3 RQ4
      end
    end
  endfunction

  function [7:0] ssd_penalty;
    input [1:0]    loc;
    input          dbl;
    input          edbl;
    input [WW-1:0] n;
    reg   [7:0]    ext;
    begin
      ext = {{(8-WW){1'b0}}, n} + `SSD_EXT_FIXED;                              // RQ8
      case (loc)
        `SSD_LOC_PORT: ssd_penalty = dbl ? `SSD_PEN2_PORT : `SSD_PEN1_PORT;    // RQ6 RQ7
        `SSD_LOC_SFR:  ssd_penalty = dbl ? `SSD_PEN2_SFR : `SSD_PEN1_SFR;      // RQ6 RQ7
        `SSD_LOC_EXT:  ssd_penalty = edbl ? {ext[6:0], 1'b0} : ext;            // RQ9
        default:       ssd_penalty = `SSD_ST_ZERO;
      endcase
    end
  endfunction

  // Shift op codes
  function ssd_is_shift;
    input [2:0] sel;
    begin
      case (sel)
        `SSD_OP_SHL: ssd_is_shift = 1'b1;
        `SSD_OP_SRA: ssd_is_shift = 1'b1;
        `SSD_OP_SRZ: ssd_is_shift = 1'b1;
        default:     ssd_is_shift = 1'b0;
      endcase
    end
  endfunction

  // Base states before any operand penalty
  function [7:0] ssd_base_states;
    input [2:0] sel;
    input       bin;
    begin
      if (sel == `SSD_OP_SWAP) begin
        ssd_base_states = `SSD_ST_SWAP;                                         // RQ5
      end else if (bin && ssd_is_shift(sel)) begin
        ssd_base_states = `SSD_ST_SH_SRC + `SSD_ST_ESC_EXTRA;                   // RQ1 RQ3 RQ10
      end else begin
        ssd_base_states = `SSD_ST_SH_SRC;                                       // RQ1 RQ3
      end
    end
  endfunction

  // Instruction length in bytes
  function [2:0] ssd_op_bytes;
    input [2:0] sel;
    input       bin;
    begin
      if (sel == `SSD_OP_SWAP) begin
        ssd_op_bytes = `SSD_BYTES_SWAP;                                         // RQ5
      end else if (bin && ssd_is_shift(sel)) begin
        ssd_op_bytes = `SSD_BYTES_SH_BIN;                                       // RQ1 RQ4
      end else begin
        ssd_op_bytes = `SSD_BYTES_SH_SRC;                                       // RQ1 RQ4
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timing

  wire        is_shift  = ssd_is_shift(op_sel);
  wire        use_esc   = binary_mode && is_shift;                                // RQ10
  wire [7:0]  base_st   = ssd_base_states(op_sel, binary_mode);                   // RQ1 RQ3 RQ5 RQ10
  wire [7:0]  pen_st    = ssd_penalty(operand_loc, pen_double, ext_double, wait_states); // RQ6 RQ7 RQ8 RQ9
  wire [7:0]  total_st  = base_st + pen_st;
  wire [2:0]  bytes_d   = ssd_op_bytes(op_sel, binary_mode);                      // RQ1 RQ4 RQ5
  wire        take      = op_valid && ready;
  wire [16:0] sh        = ssd_shift(op_sel, op_word, operand_in, carry_in);
  wire        busy;
  wire        last;

  ssd_state_timer #(.CW(8)) u_timer (
    .mclk  (mclk),
    .nrst  (nrst),
    .start (take),
    .count (total_st),
    .busy  (busy),
    .last  (last)
  );

  assign ready = !busy || last;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers

  reg [16:0] hold_q;
  reg        hold_cw_q;

  // Result and sizing capture at issue
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hold_q      <= 17'h0_0000;
      hold_cw_q   <= 1'b0;
      op_bytes_q  <= 3'h0;
      op_states_q <= 8'h00;
      illegal_q   <= 1'b0;
    end else if (take) begin
      hold_q      <= sh;
      hold_cw_q   <= is_shift;                                                  // RQ11
      op_bytes_q  <= bytes_d;
      op_states_q <= total_st;
      illegal_q   <= use_esc && !esc_prefix;                                    // RQ10
    end
  end

  // Write back in the final state
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_q     <= 16'h0000;
      carry_flag_q <= 1'b0;
    end else if (last) begin
      result_q     <= hold_q[15:0];
      carry_flag_q <= hold_q[16];
    end
  end

  // One-cycle write strobes
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      result_we_q <= 1'b0;
      carry_we_q  <= 1'b0;
    end else begin
      result_we_q <= last;
      carry_we_q  <= last && hold_cw_q;                                         // RQ11
    end
  end

endmodule // ssd_datapath

// file: core/ssd_map.vh
// Constants for the shift and nibble-swap datapath: op codes, sizes, state counts.
// Assumes inclusion by ssd_datapath.v and ssd_state_timer.v only.
`ifndef SSD_MAP_VH
`define SSD_MAP_VH

// Operation select
`define SSD_OP_SHL        3'h0
`define SSD_OP_SRA        3'h1
`define SSD_OP_SRZ        3'h2
`define SSD_OP_SWAP       3'h3

// Operand location
`define SSD_LOC_REG       2'h0
`define SSD_LOC_PORT      2'h1
`define SSD_LOC_SFR       2'h2
`define SSD_LOC_EXT       2'h3

// Instruction sizes in bytes
`define SSD_BYTES_SH_BIN  3'h3
`define SSD_BYTES_SH_SRC  3'h2
`define SSD_BYTES_SWAP    3'h1

// Base states
`define SSD_ST_SH_SRC     8'h01
`define SSD_ST_ESC_EXTRA  8'h01
`define SSD_ST_SWAP       8'h02

// Penalties
`define SSD_PEN1_PORT     8'h01
`define SSD_PEN1_SFR      8'h02
`define SSD_PEN2_PORT     8'h02
`define SSD_PEN2_SFR      8'h03
`define SSD_EXT_FIXED     8'h02

`define SSD_ST_ONE        8'h01
`define SSD_ST_ZERO       8'h00

`endif

// file: core/ssd_state_timer.v
// State counter that holds the datapath busy for a given number of states.
// Assumes start is a one-cycle pulse and the count is at least one.
`timescale 1ns/1ns
`include "ssd_map.vh"

module ssd_state_timer #(
  parameter CW = 8
) (
  input  wire          mclk,   // Core clock
  input  wire          nrst,   // Async reset, low
  input  wire          start,  // Begin counting
  input  wire [CW-1:0] count,  // States to occupy
  output wire          busy,   // Counting
  output wire          last    // Final state
);

  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = count;
    end else if (cnt_q != {CW{1'b0}}) begin
      cnt_d = cnt_q - `SSD_ST_ONE;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= {CW{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != {CW{1'b0}});
  assign last = (cnt_q == `SSD_ST_ONE);

endmodule // ssd_state_timer

// file: dv/ssd_asserts.sv
// Checker on the datapath ports: sizes, state counts, completion timing.
// Assumes bind onto ssd_datapath and no op codes above the swap.
`timescale 1ns/1ns
module ssd_asserts #(parameter WW = 4) (
  input wire          mclk,        // Clock
  input wire          nrst,        // Reset
  input wire          op_valid,    // Issue
  input wire [2:0]    op_sel,      // Op
  input wire          binary_mode, // Mode
  input wire [1:0]    operand_loc, // Place
  input wire          pen_double,  // Class
  input wire          ext_double,  // Two ext
  input wire [WW-1:0] wait_states, // N
  input wire          ready,       // Ready
  input wire          result_we_q, // Done
  input wire [2:0]    op_bytes_q,  // Bytes
  input wire [7:0]    op_states_q  // States
);
  wire       take   = op_valid && ready;
  wire       swp    = op_sel == 3'h3;
  wire [7:0] n2     = wait_states + 8'h02;
  wire [7:0] pen    = operand_loc == 2'h1 ? 8'h01 + pen_double : operand_loc == 2'h2 ? 8'h02 + pen_double :
                      operand_loc == 2'h3 ? n2 << ext_double : 8'h00;
  wire [7:0] exp_st = pen + ((swp || binary_mode) ? 8'h02 : 8'h01);
  wire [2:0] exp_by = swp ? 3'h1 : binary_mode ? 3'h3 : 3'h2;
  reg  [7:0] rem_q;
  ////////////////////////////////////////////////////////////
  // States left in the running op
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) rem_q <= 8'h00;
    else if (take) rem_q <= exp_st;
    else if (rem_q != 8'h00) rem_q <= rem_q - 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_state_count: assert property (take |=> op_states_q == $past(exp_st)) else $error("state count");
  a_byte_count: assert property (take |=> op_bytes_q == $past(exp_by)) else $error("byte count");
  a_done_time: assert property (rem_q == 8'h01 |=> result_we_q) else $error("late done");
  a_no_early: assert property (result_we_q |-> $past(rem_q) == 8'h01) else $error("early done");
  a_busy_ready: assert property (rem_q > 8'h01 |-> !ready) else $error("ready while busy");
  a_idle_ready: assert property ((rem_q < 8'h02) |-> ready) else $error("not ready");
  a_done_pulse: assert property (result_we_q && rem_q == 8'h00 |=> !result_we_q) else $error("long done");
  a_size_hold: assert property (!take |=> $stable(op_states_q) && $stable(op_bytes_q)) else $error("size moved");
  c_ext_two: cover property (take && operand_loc == 2'h3 && ext_double);
  c_sfr_dbl: cover property (take && operand_loc == 2'h2 && pen_double);
  c_swap: cover property (take && swp);
  c_back_to_back: cover property (take && rem_q == 8'h01);
endmodule // ssd_asserts
bind ssd_datapath ssd_asserts #(.WW(WW)) u_chk (
  .mclk        (mclk),
  .nrst        (nrst),
  .op_valid    (op_valid),
  .op_sel      (op_sel),
  .binary_mode (binary_mode),
  .operand_loc (operand_loc),
  .pen_double  (pen_double),
  .ext_double  (ext_double),
  .wait_states (wait_states),
  .ready       (ready),
  .result_we_q (result_we_q),
  .op_bytes_q  (op_bytes_q),
  .op_states_q (op_states_q)
);

// file: dv/tb_top.sv
// Bench for the shift and nibble-swap datapath: results, carry, sizes, states.
// Assumes ssd_datapath with default widths and the bound checker.
`timescale 1ns/1ns
module tb_top;
  reg         mclk = 0, nrst = 0, op_valid = 0, op_word = 0, binary_mode = 0, esc_prefix = 1;
  reg         pen_double = 0, ext_double = 0, carry_in = 0;
  reg  [2:0]  op_sel = 0;
  reg  [1:0]  operand_loc = 0;
  reg  [3:0]  wait_states = 0;
  reg  [15:0] operand_in = 0;
  wire        ready, carry_flag_q, carry_we_q, result_we_q, illegal_q;
  wire [15:0] result_q;
  wire [2:0]  op_bytes_q;
  wire [7:0]  op_states_q;
  integer     fails = 0, n_checks = 0, i;
  ssd_datapath dut (
    .mclk         (mclk),
    .nrst         (nrst),
    .op_valid     (op_valid),
    .op_sel       (op_sel),
    .op_word      (op_word),
    .binary_mode  (binary_mode),
    .esc_prefix   (esc_prefix),
    .operand_loc  (operand_loc),
    .pen_double   (pen_double),
    .ext_double   (ext_double),
    .wait_states  (wait_states),
    .operand_in   (operand_in),
    .carry_in     (carry_in),
    .ready        (ready),
    .result_q     (result_q),
    .carry_flag_q (carry_flag_q),
    .carry_we_q   (carry_we_q),
    .result_we_q  (result_we_q),
    .op_bytes_q   (op_bytes_q),
    .op_states_q  (op_states_q),
    .illegal_q    (illegal_q)
  );
  initial forever #2 mclk = ~mclk;
  task end_sim;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // One op, then its result, carry and sizing
  task run_op(input [2:0] s, input w, b, input [1:0] l, input d, e, input [3:0] n, input [15:0] v);
    reg [16:0] r;
    reg [7:0]  st;
    integer    k;
    begin
      case (s)
        3'h0: r = w ? {v, 1'b0} : {v[7], 8'h00, v[6:0], 1'b0};
        3'h1: r = w ? {v[0], v[15], v[15:1]} : {v[0], 8'h00, v[7], v[7:1]};
        3'h2: r = w ? {v[0], 1'b0, v[15:1]} : {v[0], 9'h000, v[7:1]};
        default: r = {9'h000, v[3:0], v[7:4]};
      endcase
      st = (s == 3'h3 || b) ? 8'h02 : 8'h01;
      if (l == 2'h1) st = st + 8'h01 + d;
      if (l == 2'h2) st = st + 8'h02 + d;
      if (l == 2'h3) st = st + ((n + 8'h02) << e);
      @(posedge mclk);
      {op_sel, op_word, binary_mode, operand_loc, pen_double, ext_double, wait_states, operand_in} <= {s, w, b, l, d, e, n, v};
      op_valid <= 1'b1;
      @(posedge mclk);
      op_valid <= 1'b0;
      for (k = 1; k < 60; k = k + 1) begin
        @(posedge mclk);
        #1;
        if (result_we_q === 1'b1) break;
      end
      chk(k, st, "states elapsed");
      chk(op_states_q, st, "state count");
      chk(op_bytes_q, s == 3'h3 ? 3'h1 : (b ? 3'h3 : 3'h2), "byte count");
      chk(result_q, r[15:0], "result");
      chk(carry_we_q, s != 3'h3, "carry enable");
      if (s != 3'h3) chk(carry_flag_q, r[16], "carry");
      chk(illegal_q, b && s != 3'h3 && !esc_prefix, "escape flag");
    end
  endtask
  task t_shifts;
    for (i = 0; i < 16; i = i + 1)
      run_op(i[3:2], i[1] && i[3:2] != 2'h3, i[0], 2'h0, 1'b0, 1'b0, 4'h0, 16'h81c3 ^ {i[3:0], 4'h0, i[3:0], 4'h0});
    $display("Test shifts done");
  endtask
  task t_penalty;
    for (i = 0; i < 8; i = i + 1)
      run_op(3'h2, 1'b0, i[0], i[2] ? 2'h2 : 2'h1, i[1], 1'b0, 4'h0, 16'h0055);
    $display("Test penalty done");
  endtask
  task t_ext;
    for (i = 0; i < 4; i = i + 1)
      run_op(3'h0, 1'b1, 1'b1, 2'h3, 1'b0, i[0], i[1] ? 4'hf : 4'h0, 16'h4001);
    $display("Test external done");
  endtask
  task t_escape;
    @(posedge mclk);
    esc_prefix <= 1'b0;
    run_op(3'h1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 4'h0, 16'h8001);
    chk(illegal_q, 1'b1, "missing escape");
    @(posedge mclk);
    esc_prefix <= 1'b1;
    $display("Test escape done");
  endtask
  ////////////////////////////////////////////////////////////
  // Second op issued in the last state of the first
  task t_back2back;
    begin
      @(posedge mclk);
      {op_sel, op_word, binary_mode, operand_loc, pen_double, ext_double, wait_states, operand_in} <=
        {3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 4'h0, 16'h0081};
      op_valid <= 1'b1;
      @(posedge mclk);
      {op_sel, operand_in} <= {3'h2, 16'h0080};
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      chk(result_we_q, 1'b1, "first done");
      chk(result_q, 16'h0002, "first result");
      chk(carry_flag_q, 1'b1, "first carry");
      chk(ready, 1'b1, "ready in last state");
      @(posedge mclk);
      #1;
      chk(result_we_q, 1'b1, "second done");
      chk(result_q, 16'h0040, "second result");
      chk(carry_flag_q, 1'b0, "second carry");
      $display("Test back to back done");
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_shifts;
    t_penalty;
    t_ext;
    t_escape;
    t_back2back;
    end_sim;
  end
  initial begin
    #20000;
    fails = fails + 1;
    end_sim;
  end
endmodule // tb_top
